// [hw/cmp_params.svh]
// Constants for the comparator control block: offsets, fields, codes and reset values
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define CMP_COUNT 3
`define CMP_NEG_SOURCES 6
`define CMP_ADDR_BITS 8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CMP_OFS_CTRL0 8'h00
`define CMP_OFS_CTRL1 8'h04
`define CMP_OFS_CTRL2 8'h08
`define CMP_OFS_STATUS 8'h0C
`define CMP_OFS_MASK 8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CMP_ON_BIT 7
`define CMP_IRQ_ON_BIT 6
`define CMP_TRIG_HI 5
`define CMP_TRIG_LO 4
`define CMP_ROUTE_BIT 3
`define CMP_NEG_HI 2
`define CMP_NEG_LO 0
`define CMP_CTRL_WMASK_PLAIN 8'hF7
`define CMP_CTRL_WMASK_ROUTE 8'hFF

// ----------------------------------------------------------------------
// Status and mask register fields
// ----------------------------------------------------------------------
`define CMP_HALVER_BIT 7
`define CMP_FLAG_LO 4
`define CMP_FLAG_HI 6
`define CMP_LEVEL_LO 0
`define CMP_LEVEL_HI 2

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define CMP_TRIG_TOGGLE 2'h0
`define CMP_TRIG_FALL 2'h2
`define CMP_TRIG_RISE 2'h3
`define CMP_NEG_LAST 3'h5
`define CMP_CTRL_RESET 8'h00
`define CMP_FLAG_RESET 3'h0
`define CMP_MASK_RESET 3'h0
`define CMP_HSIZE_WORD 3'h2

`endif

// [hw/cmp_pkg.sv]
// Types shared by the comparator control modules
`include "cmp_params.svh"
package cmp_pkg;

   // Bus phase of the register slave
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_WRITE = 4'b0010,
      PH_READ_WAIT = 4'b0100,
      PH_READ_OUT = 4'b1000
   } bus_phase_type;

   // Whole state of the top module
   typedef struct packed {
      bus_phase_type phase;
      logic [`CMP_ADDR_BITS-1:0] addr;
      logic [`CMP_COUNT-1:0][7:0] ctrl;
      logic halver;
      logic [`CMP_COUNT-1:0] flag;
      logic [`CMP_COUNT-1:0] mask;
      logic [`CMP_COUNT-1:0][`CMP_NEG_SOURCES-1:0] sync1;
      logic [`CMP_COUNT-1:0][`CMP_NEG_SOURCES-1:0] sync2;
      logic [31:0] rdata;
      logic capture_event;
   } main_state_type;

   // State of one comparator slice
   typedef struct packed {
      logic level;
      logic rose;
      logic fell;
      logic event_hit;
   } slice_state_type;

   // State of the sample-rate divider
   typedef struct packed {
      logic phase;
   } div_state_type;

endpackage

// [hw/cmp_link_if.sv]
// Signals between the top module and one comparator slice
interface cmp_link_if;
   logic sample_en;
   logic [5:0] above;
   logic [2:0] neg_sel;
   logic on;
   logic [1:0] trig_sel;
   logic level;
   logic rose;
   logic fell;
   logic event_hit;

   modport ctrl (output sample_en, above, neg_sel, on, trig_sel,
                 input level, rose, fell, event_hit);
   modport slice (input sample_en, above, neg_sel, on, trig_sel,
                  output level, rose, fell, event_hit);
endinterface

// [hw/cmp_sample_div.sv]
// Sample-rate divider: one enable per cycle, or one every second cycle
module cmp_sample_div import cmp_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic halver,
   output logic sample_en
);

   div_state_type q;
   div_state_type d;

   // Alternate phase while halving, restart when running full rate
   always_comb begin
      d = q;
      d.phase = halver ? ~q.phase : 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Full rate, or every other cycle
   assign sample_en = ~halver | q.phase;

endmodule

// [hw/cmp_slice.sv]
// One comparator: negative-input choice, sampling and event detection
`include "cmp_params.svh"
module cmp_slice import cmp_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   cmp_link_if.slice link
);

   slice_state_type q;
   slice_state_type d;
   logic result;

   // Sample the chosen decision on each enable and classify the change
   always_comb begin
      d = q;
      d.rose = 1'b0;
      d.fell = 1'b0;
      d.event_hit = 1'b0;
      result = 1'b0;
      if (link.neg_sel <= `CMP_NEG_LAST) begin
         result = link.above[link.neg_sel];
      end
      if (!link.on) begin
         d.level = 1'b0;
      end else if (link.sample_en) begin
         d.level = result;
         d.rose = result & ~q.level;
         d.fell = ~result & q.level;
         case (link.trig_sel)
            `CMP_TRIG_TOGGLE: d.event_hit = result ^ q.level;
            `CMP_TRIG_FALL: d.event_hit = ~result & q.level;
            `CMP_TRIG_RISE: d.event_hit = result & ~q.level;
            default: d.event_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.level = q.level;
   assign link.rose = q.rose;
   assign link.fell = q.fell;
   assign link.event_hit = q.event_hit;

endmodule

// [hw/analog_comparator_control.sv]
// Control, event and register logic around three clocked comparators
`include "cmp_params.svh"
module analog_comparator_control import cmp_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [17:0] above_raw,
   output logic [2:0] analog_on,
   output logic [8:0] analog_neg_sel,
   input wire logic [2:0] irq_ack,
   output logic [2:0] cmp_irq_req,
   output logic irq,
   output logic [2:0] conversion_trigger,
   input wire logic timer_capture_edge_sel,
   output logic timer_capture_in,
   output logic timer_capture_event
);

   // ----------------------------------------------------------------------
   // State and local signals
   // ----------------------------------------------------------------------
   main_state_type q;
   main_state_type d;
   logic sample_en;
   logic accept;
   logic [`CMP_COUNT-1:0] levels;
   logic [`CMP_COUNT-1:0] events;
   logic [`CMP_COUNT-1:0] irq_on;
   logic [`CMP_COUNT-1:0] route_rose;
   logic [`CMP_COUNT-1:0] route_fell;

   cmp_link_if link [`CMP_COUNT] ();

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------

   // Control register index for an offset, or the count when not a control word
   function automatic logic [1:0] ctrl_index(input logic [`CMP_ADDR_BITS-1:0] a);
      logic [1:0] idx;
      case (a)
         `CMP_OFS_CTRL0: idx = 2'h0;
         `CMP_OFS_CTRL1: idx = 2'h1;
         `CMP_OFS_CTRL2: idx = 2'h2;
         default: idx = 2'h3;
      endcase
      return idx;
   endfunction

   // Writable bits of a control register; only comparator 1 has the route bit
   function automatic logic [7:0] ctrl_wmask(input logic [1:0] idx);
      logic [7:0] m;
      m = (idx == 2'h1) ? `CMP_CTRL_WMASK_ROUTE : `CMP_CTRL_WMASK_PLAIN;
      return m;
   endfunction

   // ----------------------------------------------------------------------
   // Sample rate
   // ----------------------------------------------------------------------

   // One enable per sampling instant, halved when the halver bit is set
   cmp_sample_div sample_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .halver(q.halver),
      .sample_en(sample_en)
   );

   // ----------------------------------------------------------------------
   // Comparator slices
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `CMP_COUNT; gi = gi + 1) begin : g_cmp
         // Feed each slice its settings and the synchronised decisions
         assign link[gi].sample_en = sample_en;
         assign link[gi].above = q.sync2[gi];
         assign link[gi].neg_sel = q.ctrl[gi][`CMP_NEG_HI:`CMP_NEG_LO];
         assign link[gi].on = q.ctrl[gi][`CMP_ON_BIT];
         assign link[gi].trig_sel = q.ctrl[gi][`CMP_TRIG_HI:`CMP_TRIG_LO];

         cmp_slice slice (
            .hclk(hclk),
            .hresetn(hresetn),
            .link(link[gi])
         );

         // Results back from the slice
         assign levels[gi] = link[gi].level;
         assign events[gi] = link[gi].event_hit;
         assign route_rose[gi] = link[gi].rose;
         assign route_fell[gi] = link[gi].fell;
         assign irq_on[gi] = q.ctrl[gi][`CMP_IRQ_ON_BIT];

         // Power and mux setting for the analog side
         assign analog_on[gi] = q.ctrl[gi][`CMP_ON_BIT];
         assign analog_neg_sel[gi*3 +: 3] = q.ctrl[gi][`CMP_NEG_HI:`CMP_NEG_LO];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Bus request
   // ----------------------------------------------------------------------

   // A transfer is taken in its address phase when the bus is ready
   assign accept = hsel & htrans[1] & hready;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;
      d.capture_event = 1'b0;

      // Two-stage capture of the analog decisions
      d.sync1 = above_raw;
      d.sync2 = q.sync1;

      // Hardware clears on vector entry, only while the interrupt is enabled
      for (int i = 0; i < `CMP_COUNT; i++) begin
         if (irq_ack[i] && irq_on[i]) begin
            d.flag[i] = 1'b0;
         end
      end

      // Register write in the data phase
      if (q.phase == PH_WRITE) begin
         case (q.addr)
            `CMP_OFS_CTRL0, `CMP_OFS_CTRL1, `CMP_OFS_CTRL2: begin
               d.ctrl[ctrl_index(q.addr)] =
                  hwdata[7:0] & ctrl_wmask(ctrl_index(q.addr));
            end
            `CMP_OFS_STATUS: begin
               d.halver = hwdata[`CMP_HALVER_BIT];
               d.flag = d.flag & ~hwdata[`CMP_FLAG_HI:`CMP_FLAG_LO];
            end
            `CMP_OFS_MASK: begin
               d.mask = hwdata[`CMP_FLAG_HI:`CMP_FLAG_LO];
            end
            default: begin
               d.mask = d.mask;
            end
         endcase
      end

      // Events set flags after any clear, so a coincident event is kept
      d.flag = d.flag | events;

      // Capture event on the timer's chosen edge, only while routed
      d.capture_event = q.ctrl[1][`CMP_ROUTE_BIT] &
         (timer_capture_edge_sel ? route_rose[1] : route_fell[1]);

      // Read data is taken one cycle into the data phase
      if (q.phase == PH_READ_WAIT) begin
         d.rdata = 32'h0000_0000;
         case (q.addr)
            `CMP_OFS_CTRL0, `CMP_OFS_CTRL1, `CMP_OFS_CTRL2: begin
               d.rdata[7:0] = q.ctrl[ctrl_index(q.addr)];
            end
            `CMP_OFS_STATUS: begin
               d.rdata[`CMP_HALVER_BIT] = q.halver;
               d.rdata[`CMP_FLAG_HI:`CMP_FLAG_LO] = q.flag;
               d.rdata[`CMP_LEVEL_HI:`CMP_LEVEL_LO] = levels;
            end
            `CMP_OFS_MASK: begin
               d.rdata[`CMP_FLAG_HI:`CMP_FLAG_LO] = q.mask;
            end
            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Bus phase sequencing
      case (q.phase)
         PH_IDLE, PH_WRITE, PH_READ_OUT: begin
            if (accept && (hsize == `CMP_HSIZE_WORD)) begin
               d.addr = haddr[`CMP_ADDR_BITS-1:0];
               d.phase = hwrite ? PH_WRITE : PH_READ_WAIT;
            end else begin
               d.phase = PH_IDLE;
            end
         end
         PH_READ_WAIT: begin
            d.phase = PH_READ_OUT;
         end
         default: begin
            d.phase = PH_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.phase <= PH_IDLE;
         q.addr <= '0;
         q.ctrl <= {`CMP_CTRL_RESET, `CMP_CTRL_RESET, `CMP_CTRL_RESET};
         q.halver <= 1'b0;
         q.flag <= `CMP_FLAG_RESET;
         q.mask <= `CMP_MASK_RESET;
         q.sync1 <= '0;
         q.sync2 <= '0;
         q.rdata <= 32'h0000_0000;
         q.capture_event <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   // Reads hold one wait state, writes none; the answer is always OKAY
   assign hreadyout = (q.phase != PH_READ_WAIT);
   assign hresp = 1'b0;
   assign hrdata = q.rdata;

   // Per-comparator requests and the combined, masked interrupt
   assign cmp_irq_req = q.flag & irq_on;
   assign irq = |(cmp_irq_req & q.mask);

   // Flags offered to the converters as start triggers
   assign conversion_trigger = q.flag;

   // Comparator 1 level to the capture front end, held low unless routed
   assign timer_capture_in = q.ctrl[1][`CMP_ROUTE_BIT] & levels[1];
   assign timer_capture_event = q.capture_event;

endmodule

// [test/cmp_control_monitor.sv]
// Port checker for the comparator control block
`include "cmp_params.svh"
module cmp_control_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [2:0] analog_on,
   input wire logic [8:0] analog_neg_sel,
   input wire logic [2:0] irq_ack,
   input wire logic [2:0] cmp_irq_req,
   input wire logic irq,
   input wire logic [2:0] conversion_trigger,
   input wire logic timer_capture_edge_sel,
   input wire logic timer_capture_in,
   input wire logic timer_capture_event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_q;
   logic [7:0] wa_q;
   logic [2:0] ie_q;
   logic [2:0] mask_q;
   logic route_q;
   // Shadow of the written enable, mask and route bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         ie_q <= 3'h0;
         mask_q <= 3'h0;
         route_q <= 1'b0;
      end else begin
         if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite && hsize == `CMP_HSIZE_WORD;
            wa_q <= haddr[7:0];
         end
         if (wr_q) begin
            for (int k = 0; k < 3; k++) begin
               if (wa_q == 8'(4 * k)) ie_q[k] <= hwdata[6];
            end
            if (wa_q == `CMP_OFS_CTRL1) route_q <= hwdata[3];
            if (wa_q == `CMP_OFS_MASK) mask_q <= hwdata[6:4];
         end
      end
   end
   AST_IRQ_REQ: assert property (cmp_irq_req == (conversion_trigger & ie_q))
      else $error("request not flag and enable");
   AST_IRQ_OUT: assert property (irq == |(cmp_irq_req & mask_q))
      else $error("irq not masked requests");
   AST_ROUTE_OFF: assert property (!route_q |-> !timer_capture_in)
      else $error("capture input without route");
   AST_CAPTURE_EDGE: assert property (timer_capture_event |-> $past(route_q) &&
      $past(timer_capture_in) == $past(timer_capture_edge_sel))
      else $error("capture on wrong edge");
   AST_CAPTURE_FOLLOWS: assert property ($changed(timer_capture_in) &&
      $stable(route_q) && analog_on[1]
      |=> timer_capture_event == ($past(timer_capture_in) == $past(timer_capture_edge_sel)))
      else $error("capture event missing");
   for (genvar i = 0; i < 3; i++) begin : g_cmp
      AST_CTRL_WRITE: assert property (wr_q && wa_q == 8'(4 * i)
         |=> analog_on[i] == $past(hwdata[7]) && analog_neg_sel[3*i+:3] == $past(hwdata[2:0]))
         else $error("control fields not applied");
      AST_FLAG_CLEAR: assert property ($fell(conversion_trigger[i]) |->
         $past(irq_ack[i] && cmp_irq_req[i]) ||
         $past(wr_q && wa_q == `CMP_OFS_STATUS && hwdata[4+i]))
         else $error("flag cleared without cause");
      AST_FLAG_ENABLED: assert property ($rose(conversion_trigger[i]) |->
         $past(analog_on[i], 2))
         else $error("flag set while disabled");
   end
   // Main scenarios
   cover property (timer_capture_event);
   cover property (irq);
   cover property ($fell(conversion_trigger[0]));
endmodule
bind analog_comparator_control cmp_control_monitor u_monitor (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .analog_on, .analog_neg_sel, .irq_ack,
   .cmp_irq_req, .irq, .conversion_trigger, .timer_capture_edge_sel, .timer_capture_in,
   .timer_capture_event);

// [test/timer_capture_model.sv]
// Timer side model: capture edge select and capture interrupt count
module timer_capture_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic edge_cfg,
   input wire logic timer_capture_irq_on,
   input wire logic timer_capture_event,
   output logic timer_capture_edge_sel,
   output logic [7:0] capture_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // Edge select register and counter of taken capture interrupts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_capture_edge_sel <= 1'b0;
         capture_count <= 8'h00;
      end else begin
         timer_capture_edge_sel <= edge_cfg;
         if (timer_capture_event && timer_capture_irq_on) begin
            capture_count <= capture_count + 8'h01;
         end
      end
   end
endmodule

// [test/testbench.sv]
// Self-checking bench for the comparator control block
`include "cmp_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [17:0] above_raw = 18'h0_0000;
   logic [2:0] irq_ack = 3'h0;
   logic edge_cfg = 1'b0;
   logic hreadyout, hresp, irq, tin, tev, tsel;
   logic rd_q = 1'b0;
   logic [31:0] hrdata;
   logic [31:0] hv = 32'h0000_0000;
   logic [2:0] on, req, trig, lv;
   logic [8:0] nsel;
   logic [7:0] cnt, base, v;
   int n0, n1;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 32'ha80a_3c02;
   logic [31:0] exp_q[$];
   logic [31:0] care_q[$];
   always #5 hclk = ~hclk;
   analog_comparator_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .above_raw, .analog_on(on),
      .analog_neg_sel(nsel), .irq_ack, .cmp_irq_req(req), .irq, .conversion_trigger(trig),
      .timer_capture_edge_sel(tsel), .timer_capture_in(tin), .timer_capture_event(tev));
   timer_capture_model u_timer (.hclk, .hresetn, .edge_cfg, .timer_capture_irq_on(1'b1),
      .timer_capture_event(tev), .timer_capture_edge_sel(tsel), .capture_count(cnt));
   // ----
   // Tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      care_q.push_back(m);
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic poke(input int k, input logic lvl, input logic hit);
      logic [2:0] e;
      xfer(1'b1, `CMP_OFS_STATUS, hv | 32'h0000_0070);
      above_raw[6 * k] <= lvl;
      step(8);
      e = hit ? 3'(1 << k) : 3'h0;
      check({24'h0, hresp, irq, req, trig}, {24'h0, 1'b0, |e, e, e});
   endtask
   task automatic ack();
      irq_ack <= 3'h1;
      step(1);
      irq_ack <= 3'h0;
      step(2);
   endtask
   task automatic lat(input int pre, output int n);
      above_raw[0] <= 1'b0;
      step(8);
      xfer(1'b1, `CMP_OFS_STATUS, hv | 32'h0000_0070);
      step(pre);
      above_raw[0] <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (trig[0] !== 1'b1 && n < 20);
      // A flag that never rises ends the run as a failure
      if (trig[0] !== 1'b1) begin
         mismatches++;
         complete_run();
      end
   endtask
   // Read watcher: each completed read against the oldest note
   always @(posedge hclk) begin
      if (rd_q === 1'b1 && hreadyout === 1'b1) begin
         check(hrdata & care_q.pop_front(), exp_q.pop_front());
      end
      if (hreadyout === 1'b1) rd_q <= hsel && htrans[1] && !hwrite;
   end
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, unmapped offset reads zero
      for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h0000_0000, 32'hFFFF_FFFF);
      // Random control values read back, reserved bit zero
      for (int k = 0; k < 3; k++) begin
         v = 8'($random(seed));
         xfer(1'b1, 8'(4 * k), {24'h00_0000, v});
         rd(8'(4 * k), {24'h0, v & (k == 1 ? `CMP_CTRL_WMASK_ROUTE : `CMP_CTRL_WMASK_PLAIN)},
            32'hFFFF_FFFF);
      end
      xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
      rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
      // Every negative source against random decisions
      for (int s = 0; s < 8; s++) begin
         above_raw <= 18'($random(seed));
         for (int k = 0; k < 3; k++) xfer(1'b1, 8'(4 * k), {24'h0, 8'h80 | 8'(s)});
         step(8);
         for (int k = 0; k < 3; k++) lv[k] = (s < 6) ? above_raw[6 * k + s] : 1'b0;
         rd(`CMP_OFS_STATUS, {29'h0, lv}, 32'h0000_0007);
         check(32'(nsel), 32'({3{3'(s)}}));
      end
      // Every trigger code on every comparator
      above_raw <= 18'h0_0000;
      xfer(1'b1, `CMP_OFS_MASK, 32'h0000_0070);
      for (int k = 0; k < 3; k++) begin
         for (int t = 0; t < 4; t++) begin
            xfer(1'b1, 8'(4 * k), {24'h0, 8'hC0 | 8'(t << 4)});
            poke(k, 1'b1, t == 0 || t == 3);
            poke(k, 1'b0, t == 0 || t == 2);
         end
      end
      // Mask, interrupt enable and acknowledge
      poke(0, 1'b1, 1'b1);
      xfer(1'b1, `CMP_OFS_MASK, 32'h0000_0000);
      step(1);
      check(32'({irq, req, trig}), 32'h0000_0009);
      xfer(1'b1, `CMP_OFS_CTRL0, 32'h0000_00B0);
      step(1);
      check(32'({irq, req, trig}), 32'h0000_0001);
      ack();
      check(32'({irq, req, trig}), 32'h0000_0001);
      xfer(1'b1, `CMP_OFS_CTRL0, 32'h0000_00F0);
      ack();
      check(32'({irq, req, trig}), 32'h0000_0000);
      // Sample rate: full rate fixed latency, half rate depends on phase
      xfer(1'b1, `CMP_OFS_CTRL0, 32'h0000_00B0);
      for (int h = 0; h < 2; h++) begin
         hv = h ? 32'h0000_0080 : 32'h0000_0000;
         xfer(1'b1, `CMP_OFS_STATUS, hv);
         rd(`CMP_OFS_STATUS, hv, 32'h0000_0080);
         lat(0, n0);
         lat((n0 + 1) % 2, n1);
         if (h) check(32'(n0 - n1 == 1 || n1 - n0 == 1), 32'h0000_0001);
         else check({n0[15:0], n1[15:0]}, 32'h0005_0005);
      end
      hv = 32'h0000_0000;
      xfer(1'b1, `CMP_OFS_STATUS, 32'h0000_0070);
      // Capture route and edge select, all four combinations
      for (int c = 0; c < 4; c++) begin
         edge_cfg <= c[0];
         xfer(1'b1, `CMP_OFS_CTRL1, {24'h0, c[1] ? 8'h88 : 8'h80});
         base = cnt;
         above_raw[6] <= 1'b1;
         step(8);
         check(32'({tin, 8'(cnt - base)}), 32'({c[1], 8'(c[1] & c[0])}));
         above_raw[6] <= 1'b0;
         step(8);
         check(32'(8'(cnt - base)), 32'(c[1]));
      end
      complete_run();
   end
endmodule
